// ==== atr_task_file.sv ====
`timescale 1ns/1ps
module atr_task_file
  import atr_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_i,
  input  wire logic      link_reset_i,
  input  wire atr_acc_t  acc_i,
  input  wire atr_done_t done_i,
  input  wire logic      powered_up_i,
  input  wire logic      seek_start_i,
  input  wire logic      seek_settled_i,
  input  wire logic      standby_i,
  input  wire logic      data_req_i,
  input  wire logic      selected_i,
  output logic [7:0]     rdata_o,
  output logic           cmd_start_o,
  output logic [7:0]     cmd_code_o,
  output logic [7:0]     feature_o,
  output logic [7:0]     feature_prev_o,
  output logic           lba_mode_o,
  output logic [47:0]    lba_o,
  output logic [16:0]    sectors_o,
  output logic           dev_reset_o,
  output logic           irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] count_cur, count_prev, a0_cur, a0_prev;
  logic [7:0] a1_cur, a1_prev, a2_cur, a2_prev;
  logic [7:0] head, ctrl, err_reg;
  logic       busy, ready, seek, err_flag, irq_pend, rdy_hold;
  logic       hob_next_wr;
  atr_state_t state;
  logic       soft_clr;
  logic       cb_wr, cmd_wr, ctrl_wr, stat_rd;
  logic [7:0] status;

  assign cb_wr   = acc_i.wr && (acc_i.idx != REG_MIRROR_CTRL);
  assign cmd_wr  = acc_i.wr && (acc_i.idx == REG_STAT_CMD);
  assign ctrl_wr = acc_i.wr && (acc_i.idx == REG_MIRROR_CTRL);
  assign stat_rd = acc_i.rd && (acc_i.idx == REG_STAT_CMD);
  assign soft_clr = link_reset_i || ctrl[CT_SOFT_RESET_BIT];
  assign hob_next_wr = 1'b0;

  // fault, corrected and revolution bits held low
  assign status = {busy, ready, 1'b0, seek, data_req_i, 1'b0, 1'b0,
                   err_flag};

  ////////////////////////////////////////////////////////////////////////////
  // address/count byte pairs, updated at completion
  atr_byte_pair #(.RST_VAL(RST_ONE)) u_count (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (soft_clr),
    .wr_i     (acc_i.wr && acc_i.idx == REG_COUNT && !busy),
    .wdata_i  (acc_i.data),
    .upd_i    (done_i.done && state == ST_EXEC),
    .upd_val_i(done_i.left),
    .cur_o    (count_cur),
    .prev_o   (count_prev)
  );
  atr_byte_pair #(.RST_VAL(RST_ONE)) u_a0 (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (soft_clr),
    .wr_i     (acc_i.wr && acc_i.idx == REG_ADDR0 && !busy),
    .wdata_i  (acc_i.data),
    .upd_i    (done_i.done && state == ST_EXEC),
    .upd_val_i({done_i.addr[31:24], done_i.addr[7:0]}),
    .cur_o    (a0_cur),
    .prev_o   (a0_prev)
  );
  atr_byte_pair #(.RST_VAL(RST_ZERO)) u_a1 (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (soft_clr),
    .wr_i     (acc_i.wr && acc_i.idx == REG_ADDR1 && !busy),
    .wdata_i  (acc_i.data),
    .upd_i    (done_i.done && state == ST_EXEC),
    .upd_val_i({done_i.addr[39:32], done_i.addr[15:8]}),
    .cur_o    (a1_cur),
    .prev_o   (a1_prev)
  );
  atr_byte_pair #(.RST_VAL(RST_ZERO)) u_a2 (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .clr_i    (soft_clr),
    .wr_i     (acc_i.wr && acc_i.idx == REG_ADDR2 && !busy),
    .wdata_i  (acc_i.data),
    .upd_i    (done_i.done && state == ST_EXEC),
    .upd_val_i({done_i.addr[47:40], done_i.addr[23:16]}),
    .cur_o    (a2_cur),
    .prev_o   (a2_prev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interface control; soft reset bit survives its own clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= RST_ZERO;
    end else if (link_reset_i) begin
      ctrl <= RST_ZERO;
    end else if (ctrl_wr) begin
      ctrl <= acc_i.data;
    end else if (cb_wr) begin
      ctrl[CT_HOB] <= hob_next_wr;
    end
  end

  // head register, drive select kept but unused
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      head <= RST_ZERO;
    end else if (soft_clr) begin
      head <= RST_ZERO;
    end else if (done_i.done && state == ST_EXEC) begin
      head[3:0] <= done_i.addr[27:24];
    end else if (acc_i.wr && acc_i.idx == REG_HEAD && !busy) begin
      head <= acc_i.data;
    end
  end

  // features and command code latches
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      feature_o      <= RST_ZERO;
      feature_prev_o <= RST_ZERO;
      cmd_code_o     <= RST_ZERO;
    end else begin
      if (acc_i.wr && acc_i.idx == REG_ERR_FEAT && !busy) begin
        feature_o      <= acc_i.data;
        feature_prev_o <= feature_o;
      end
      if (cmd_wr && !busy) begin
        cmd_code_o <= acc_i.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= ST_RESET;
      cmd_start_o <= 1'b0;
      busy        <= 1'b1;
    end else begin
      cmd_start_o <= 1'b0;
      case (state)
        ST_RESET: begin
          busy <= 1'b1;
          if (!soft_clr) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (soft_clr) begin
            state <= ST_RESET;
            busy  <= 1'b1;
          end else if (cmd_wr) begin
            state       <= ST_EXEC;
            cmd_start_o <= 1'b1;
            busy        <= 1'b1;
          end
        end
        ST_EXEC: begin
          if (soft_clr) begin
            state <= ST_RESET;
          end else if (done_i.done) begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // error register and flag
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      err_reg  <= DIAG_OK;
      err_flag <= 1'b0;
    end else if (soft_clr) begin
      err_reg  <= DIAG_OK;
      err_flag <= 1'b0;
    end else if (done_i.done && state == ST_EXEC) begin
      err_reg  <= done_i.load_diag ? done_i.err : (done_i.err & ERR_MASK);
      err_flag <= done_i.fail;
    end else if (cmd_wr && state == ST_IDLE) begin
      err_flag <= 1'b0;
    end
  end

  // ready and seek settled, held after error until status read
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready    <= 1'b1;
      seek     <= 1'b1;
      rdy_hold <= 1'b0;
    end else if (soft_clr) begin
      ready    <= powered_up_i;
      seek     <= seek_settled_i || standby_i;
      rdy_hold <= 1'b0;
    end else if (done_i.done && state == ST_EXEC && done_i.fail) begin
      ready    <= 1'b0;
      rdy_hold <= 1'b1;
    end else if (rdy_hold) begin
      // only an error holds ready low; power-up low follows the pin
      if (stat_rd) begin
        ready    <= powered_up_i;
        seek     <= seek_settled_i || standby_i;
        rdy_hold <= 1'b0;
      end
    end else begin
      ready <= powered_up_i;
      if (standby_i || seek_settled_i) begin
        seek <= 1'b1;
      end else if (seek_start_i) begin
        seek <= 1'b0;
      end
    end
  end

  // interrupt pending; completion wins over an acknowledge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_pend <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      if (done_i.done && state == ST_EXEC) begin
        irq_pend <= 1'b1;
      end else if (stat_rd || soft_clr) begin
        irq_pend <= 1'b0;
      end
      irq_o <= irq_pend && !ctrl[CT_IEN] && selected_i
               && !(stat_rd && !(done_i.done && state == ST_EXEC));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; mirror read does not touch the interrupt
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= RST_STATUS;
    end else if (acc_i.rd) begin
      if (busy) begin
        rdata_o <= status;
      end else if (acc_i.idx == REG_ERR_FEAT) begin
        rdata_o <= err_reg;
      end else if (acc_i.idx == REG_COUNT) begin
        rdata_o <= ctrl[CT_HOB] ? count_prev : count_cur;
      end else if (acc_i.idx == REG_ADDR0) begin
        rdata_o <= ctrl[CT_HOB] ? a0_prev : a0_cur;
      end else if (acc_i.idx == REG_ADDR1) begin
        rdata_o <= ctrl[CT_HOB] ? a1_prev : a1_cur;
      end else if (acc_i.idx == REG_ADDR2) begin
        rdata_o <= ctrl[CT_HOB] ? a2_prev : a2_cur;
      end else if (acc_i.idx == REG_HEAD) begin
        rdata_o <= head;
      end else if (acc_i.idx == REG_STAT_CMD ||
                   acc_i.idx == REG_MIRROR_CTRL) begin
        rdata_o <= status;
      end else begin
        rdata_o <= RST_ZERO;
      end
    end
  end

  // decoded command parameters
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lba_mode_o  <= 1'b0;
      lba_o       <= '0;
      sectors_o   <= '0;
      dev_reset_o <= 1'b1;
    end else begin
      lba_mode_o  <= head[HD_LBA];
      lba_o       <= {a2_prev, a1_prev, a0_prev, a2_cur, a1_cur, a0_cur};
      sectors_o   <= {({count_prev, count_cur} == 16'h0000), count_prev,
                      count_cur};
      dev_reset_o <= soft_clr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_clr_on_cmd;
    @(posedge mclk_i) disable iff (rst_i)
      (cmd_wr && state == ST_IDLE && !soft_clr) |=> !err_flag;
  endproperty
  a_clr_on_cmd: assert property (p_clr_on_cmd)
    else $error("error flag not cleared by command");

  property p_start;
    @(posedge mclk_i) disable iff (rst_i)
      (cmd_wr && state == ST_IDLE && !soft_clr) |=> cmd_start_o && busy;
  endproperty
  a_start: assert property (p_start)
    else $error("command did not start");

  property p_hob;
    @(posedge mclk_i) disable iff (rst_i)
      (cb_wr && !link_reset_i) |=> !ctrl[CT_HOB];
  endproperty
  a_hob: assert property (p_hob)
    else $error("high byte select not cleared");

  property p_soft_reset_bit;
    @(posedge mclk_i) disable iff (rst_i)
      ctrl[CT_SOFT_RESET_BIT] |=> dev_reset_o && busy;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit)
    else $error("soft reset not held");

  property p_irq_mask;
    @(posedge mclk_i) disable iff (rst_i)
      (ctrl[CT_IEN] || !selected_i) |=> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt not suppressed");

  property p_ack;
    @(posedge mclk_i) disable iff (rst_i)
      (stat_rd && !(done_i.done && state == ST_EXEC)) |=> !irq_pend;
  endproperty
  a_ack: assert property (p_ack)
    else $error("status read did not clear interrupt");

  property p_busy_read;
    @(posedge mclk_i) disable iff (rst_i)
      (acc_i.rd && busy) |=> rdata_o == $past(status);
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("busy read did not return status");

  property p_err_zero;
    @(posedge mclk_i) disable iff (rst_i)
      (done_i.done && state == ST_EXEC && !done_i.load_diag && !soft_clr)
      |=> (err_reg & ~ERR_MASK) == RST_ZERO;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("reserved error bits set");

  c_cmd: cover property (@(posedge mclk_i) disable iff (rst_i)
    cmd_start_o ##[1:20] (done_i.done && state == ST_EXEC));
  c_fail: cover property (@(posedge mclk_i) disable iff (rst_i)
    !ready ##[1:20] stat_rd);
  c_reset: cover property (@(posedge mclk_i) disable iff (rst_i)
    ctrl[CT_SOFT_RESET_BIT] ##[1:20] (state == ST_IDLE));
endmodule

// ==== atr_pkg.sv ====
package atr_pkg;

  // register indices on the task-file port
  localparam logic [3:0] REG_DATA_IDX    = 4'h0;
  localparam logic [3:0] REG_ERR_FEAT    = 4'h1;
  localparam logic [3:0] REG_COUNT       = 4'h2;
  localparam logic [3:0] REG_ADDR0       = 4'h3;
  localparam logic [3:0] REG_ADDR1       = 4'h4;
  localparam logic [3:0] REG_ADDR2       = 4'h5;
  localparam logic [3:0] REG_HEAD        = 4'h6;
  localparam logic [3:0] REG_STAT_CMD    = 4'h7;
  localparam logic [3:0] REG_MIRROR_CTRL = 4'hE;

  // status bits
  localparam int ST_BUSY  = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK  = 4;
  localparam int ST_DREQ  = 3;
  localparam int ST_CORRECTED_FLAG  = 2;
  localparam int ST_REV   = 1;
  localparam int ST_ERR   = 0;

  // interface control bits
  localparam int CT_HOB  = 7;
  localparam int CT_SOFT_RESET_BIT = 2;
  localparam int CT_IEN  = 1;

  // head register bits
  localparam int HD_LBA = 6;
  localparam int HD_DRV = 4;

  // error bit mask: bits 5, 3, 0 read zero
  localparam logic [7:0] ERR_MASK = 8'hD6;

  localparam logic [7:0] RST_STATUS = 8'h50;
  localparam logic [7:0] RST_ONE    = 8'h01;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] DIAG_OK    = 8'h01;

  // task-file access from the link layer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] idx;
    logic [7:0] data;
  } atr_acc_t;

  // completion report from the media engine
  typedef struct packed {
    logic        done;
    logic        fail;
    logic        load_diag;
    logic [7:0]  err;
    logic [15:0] left;
    logic [47:0] addr;
  } atr_done_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RESET = 2'b01,
    ST_EXEC  = 2'b10
  } atr_state_t;

endpackage

// ==== atr_byte_pair.sv ====
`timescale 1ns/1ps
// two-deep byte register: current and previous write
module atr_byte_pair
  import atr_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       clr_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       upd_i,
  input  wire logic [15:0] upd_val_i,
  output logic [7:0]      cur_o,
  output logic [7:0]      prev_o
);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_o  <= RST_VAL;
      prev_o <= RST_ZERO;
    end else if (clr_i) begin
      cur_o  <= RST_VAL;
      prev_o <= RST_ZERO;
    end else if (upd_i) begin
      cur_o  <= upd_val_i[7:0];
      prev_o <= upd_val_i[15:8];
    end else if (wr_i) begin
      cur_o  <= wdata_i;
      prev_o <= cur_o;
    end
  end
endmodule

// ==== atr_host_model.sv ====
`timescale 1ns/1ps
module atr_host_model
  import atr_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       data_req_i,
  input  wire logic [7:0] rdata_i,
  output atr_acc_t        acc_o
);
  logic shadow_busy;

  initial begin
    acc_o       = '0;
    shadow_busy = 1'b0;
  end

  // one-cycle access, then released lines show inverted values
  task automatic access(input logic w, input logic [3:0] idx,
                        input logic [7:0] d);
    @(negedge mclk_i);
    acc_o = '{wr: w, rd: !w, idx: idx, data: d};
    @(negedge mclk_i);
    acc_o = '{wr: 1'b0, rd: 1'b0, idx: ~idx, data: ~d};
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    access(1'b1, idx, d);
  endtask

  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    access(1'b0, idx, 8'h00);
    d = rdata_i;
    if (idx == REG_STAT_CMD && !d[ST_BUSY]) begin
      shadow_busy = 1'b0;
    end
  endtask

  // caller loads every operand register before this
  task automatic cmd(input logic [7:0] code);
    int n;
    n = 0;
    while (data_req_i && n < 1000) begin
      @(negedge mclk_i);
      n++;
    end
    shadow_busy = 1'b1;
    wr(REG_STAT_CMD, code);
  endtask

  // 500 cycles is 5 us at 100 MHz
  task automatic soft_reset(input logic [7:0] ctrl);
    shadow_busy = 1'b1;
    wr(REG_MIRROR_CTRL, ctrl | 8'h04);
    repeat (500) @(negedge mclk_i);
    wr(REG_MIRROR_CTRL, ctrl & 8'hFB);
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
  import atr_pkg::*;
;
  typedef struct packed {
    logic [3:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } atr_row_t;

  logic        mclk_i, rst_i, link_reset_i, powered_up_i, seek_start_i;
  logic        seek_settled_i, standby_i, data_req_i, selected_i;
  atr_acc_t    acc_i;
  atr_done_t   done_i;
  logic [7:0]  rdata_o, cmd_code_o, feature_o;
  logic        cmd_start_o, lba_mode_o, dev_reset_o, irq_o;
  logic [47:0] lba_o;
  logic [16:0] sectors_o;
  int          failures, compares, cycles;
  atr_row_t    rows [7] = '{
    '{REG_COUNT, 8'hA5, 8'hA5}, '{REG_ADDR0, 8'h12, 8'h12},
    '{REG_ADDR1, 8'h34, 8'h34}, '{REG_ADDR2, 8'h56, 8'h56},
    '{REG_HEAD, 8'hA3, 8'hA3}, '{REG_ERR_FEAT, 8'h77, DIAG_OK},
    '{REG_MIRROR_CTRL, 8'h08, RST_STATUS}};

  atr_task_file i_atr_task_file (
    .mclk_i(mclk_i), .rst_i(rst_i), .link_reset_i(link_reset_i),
    .acc_i(acc_i), .done_i(done_i), .powered_up_i(powered_up_i),
    .seek_start_i(seek_start_i), .seek_settled_i(seek_settled_i),
    .standby_i(standby_i), .data_req_i(data_req_i),
    .selected_i(selected_i), .rdata_o(rdata_o),
    .cmd_start_o(cmd_start_o), .cmd_code_o(cmd_code_o),
    .feature_o(feature_o), .feature_prev_o(), .lba_mode_o(lba_mode_o),
    .lba_o(lba_o), .sectors_o(sectors_o), .dev_reset_o(dev_reset_o),
    .irq_o(irq_o));

  atr_host_model i_atr_host_model (
    .mclk_i(mclk_i), .data_req_i(data_req_i), .rdata_i(rdata_o),
    .acc_o(acc_i));

  always #5 mclk_i = ~mclk_i;

  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("MISMATCH t=%0t run exceeded cycle limit", $time);
      summarize();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp,
                       input string msg);
    logic [7:0] d;
    i_atr_host_model.rd(idx, d);
    chk(48'(d), 48'(exp), msg);
  endtask

  // completion pulse, then two cycles for flags and irq to land
  task automatic finish_cmd(input logic fail, input logic [7:0] err,
                            input logic [15:0] left, input logic [47:0] a);
    @(negedge mclk_i);
    done_i = '{done: 1'b1, fail: fail, load_diag: 1'b0, err: err,
               left: left, addr: a};
    @(negedge mclk_i);
    done_i = '0;
    repeat (2) @(negedge mclk_i);
  endtask

  task automatic check_defaults(input string name);
    rdchk(REG_COUNT, RST_ONE, "count default");
    rdchk(REG_ADDR0, RST_ONE, "addr0 default");
    rdchk(REG_ADDR1, RST_ZERO, "addr1 default");
    rdchk(REG_ADDR2, RST_ZERO, "addr2 default");
    rdchk(REG_HEAD, RST_ZERO, "head default");
    rdchk(REG_STAT_CMD, RST_STATUS, "status default");
    rdchk(REG_MIRROR_CTRL, RST_STATUS, "mirror default");
    rdchk(REG_ERR_FEAT, DIAG_OK, "diag code");
    $display("test %s done", name);
  endtask

  initial begin
    logic [7:0] d;
    mclk_i = 1'b0;
    rst_i = 1'b1;
    link_reset_i = 1'b0;
    done_i = '0;
    powered_up_i = 1'b1;
    seek_start_i = 1'b0;
    seek_settled_i = 1'b1;
    standby_i = 1'b0;
    data_req_i = 1'b0;
    selected_i = 1'b1;
    repeat (12) @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    check_defaults("power-on");
    foreach (rows[i]) begin
      i_atr_host_model.wr(rows[i].idx, rows[i].wdata);
      rdchk(rows[i].idx, rows[i].rdata, "readback");
    end
    chk(48'(feature_o), 48'h77, "feature latch");
    $display("test table done");
    i_atr_host_model.wr(REG_ADDR0, 8'h11);
    i_atr_host_model.wr(REG_ADDR0, 8'h22);
    i_atr_host_model.wr(REG_COUNT, 8'h00);
    i_atr_host_model.wr(REG_COUNT, 8'h00);
    // decoded outputs are registered one cycle behind the registers
    @(negedge mclk_i);
    chk(48'(sectors_o), 48'h1_0000, "zero count");
    chk(48'({lba_o[31:24], lba_o[7:0]}), 48'h1122, "pair");
    i_atr_host_model.wr(REG_MIRROR_CTRL, 8'h88);
    rdchk(REG_ADDR0, 8'h11, "high byte read");
    i_atr_host_model.wr(REG_ADDR1, 8'h44);
    rdchk(REG_ADDR0, 8'h22, "select cleared");
    $display("test high byte done");
    i_atr_host_model.wr(REG_HEAD, 8'hF0);
    i_atr_host_model.cmd(8'hC8);
    chk(48'(cmd_start_o), 48'h1, "start pulse");
    chk(48'(cmd_code_o), 48'hC8, "code");
    chk(48'(lba_mode_o), 48'h1, "lba mode");
    i_atr_host_model.rd(REG_ADDR1, d);
    chk(48'(d[ST_BUSY]), 48'h1, "busy read");
    finish_cmd(1'b0, 8'h00, 16'h0000, 48'h0000_0A0B_0C0D);
    chk(48'(irq_o), 48'h1, "irq raised");
    rdchk(REG_ADDR0, 8'h0D, "lba 0-7");
    rdchk(REG_ADDR1, 8'h0C, "lba 8-15");
    rdchk(REG_ADDR2, 8'h0B, "lba 16-23");
    i_atr_host_model.rd(REG_HEAD, d);
    chk(48'(d[3:0]), 48'hA, "lba 24-27");
    rdchk(REG_COUNT, 8'h00, "count left");
    rdchk(REG_MIRROR_CTRL, RST_STATUS, "mirror");
    chk(48'(irq_o), 48'h1, "irq kept");
    rdchk(REG_STAT_CMD, RST_STATUS, "status");
    @(negedge mclk_i);
    chk(48'(irq_o), 48'h0, "irq acked");
    $display("test command done");
    for (int k = 0; k < 2; k++) begin
      i_atr_host_model.wr(REG_MIRROR_CTRL, (k == 0) ? 8'h0A : 8'h08);
      selected_i = (k == 0);
      i_atr_host_model.cmd(8'h20);
      finish_cmd(1'b0, 8'h00, 16'h0000, 48'h0);
      chk(48'(irq_o), 48'h0, "irq suppressed");
      rdchk(REG_STAT_CMD, RST_STATUS, "status");
    end
    selected_i = 1'b1;
    $display("test irq mask done");
    i_atr_host_model.cmd(8'h20);
    finish_cmd(1'b1, 8'hFF, 16'h0003, 48'h0);
    seek_settled_i = 1'b0;
    rdchk(REG_ERR_FEAT, 8'hFF & ERR_MASK, "error bits");
    rdchk(REG_COUNT, 8'h03, "sectors left");
    rdchk(REG_STAT_CMD, 8'h11, "error status");
    rdchk(REG_STAT_CMD, 8'h41, "after read");
    seek_settled_i = 1'b1;
    i_atr_host_model.cmd(8'h20);
    finish_cmd(1'b0, 8'h00, 16'h0000, 48'h0);
    rdchk(REG_STAT_CMD, RST_STATUS, "error cleared");
    data_req_i = 1'b1;
    @(negedge mclk_i);
    rdchk(REG_STAT_CMD, 8'h58, "data request");
    // command held back until the data request drops
    fork
      i_atr_host_model.cmd(8'h20);
      begin
        repeat (4) @(negedge mclk_i);
        data_req_i = 1'b0;
      end
    join
    @(negedge mclk_i);
    done_i = '{done: 1'b1, fail: 1'b0, load_diag: 1'b1, err: DIAG_OK,
               left: 16'h0000, addr: 48'h0};
    @(negedge mclk_i);
    done_i = '0;
    rdchk(REG_ERR_FEAT, DIAG_OK, "diag code kept");
    powered_up_i = 1'b0;
    seek_settled_i = 1'b0;
    standby_i = 1'b1;
    @(negedge mclk_i);
    rdchk(REG_STAT_CMD, 8'h10, "power-up standby");
    powered_up_i = 1'b1;
    seek_settled_i = 1'b1;
    standby_i = 1'b0;
    $display("test error done");
    fork
      i_atr_host_model.soft_reset(8'h08);
      begin
        repeat (10) @(negedge mclk_i);
        chk(48'(dev_reset_o), 48'h1, "held in reset");
      end
    join
    repeat (2) @(negedge mclk_i);
    chk(48'(dev_reset_o), 48'h0, "released");
    check_defaults("soft reset");
    i_atr_host_model.wr(REG_ADDR1, 8'h5A);
    link_reset_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    link_reset_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    check_defaults("link reset");
    summarize();
  end
endmodule
